// *** hdl/ras_return_address_stack.sv ***
// ras_return_address_stack: 31-entry return-address stack, pointer
// register, top-entry registers and one-level fast shadow registers.
// assumes: sequencer gives at most one command a cycle, synchronous to
// clk; rstn is the power-on reset; dev_reset_n covers the other resets.
//
// Summary of operation
// [RL1] 31 entries of 21 bits, 5-bit pointer.
// [RL2] push pc on call or interrupt acknowledge.
// [RL3] pop into pc on return-type instructions.
// [RL4] calls and returns never touch pc latches.
// [RL5] push: bump pointer, then write entry.
// [RL6] pop: read entry, then drop pointer.
// [RL7] every reset zeroes pointer; zero is empty.
// [RL8] top-entry registers access selected entry only.
// [RL9] software reads and writes pointer 0..31.
// [RL10] full flag after 31 unpopped pushes.
// [RL11] error reset on: store pc+2, reset.
// [RL12] error reset off: pointer stays 31.
// [RL13] pop at zero: pc zero, underflow.
// [RL14] option decides reset on full/underflow.
// [RL15] flags cleared only by software or power-on.
// [RL16] pointer reg: full7, under6, zero5, pointer.
// [RL17] software push stores current pc.
// [RL18] software pop only decrements pointer.
// [RL19] interrupt vectoring loads shadow copies.
// [RL20] fast returns restore from shadow copies.
// [RL21] fast call saves into shadow copies.
// [RL22] software masks interrupts around top access.
// [RL23] shadow has one level, newest wins.
// [RL24] pc even: bit zero always zero.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ras_return_address_stack (
  input  wire logic                             clk,
  input  wire logic                             rstn,
  input  wire logic                             dev_reset_n,
  input  wire ras_pkg::ras_req_t                req,
  output var  ras_pkg::ras_rsp_t                rsp,
  output var  logic                             stack_full_flag,
  output var  logic                             stack_underflow_flag,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [ras_pkg::RAS_ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output var  logic [31:0]                      wb_dat_o,
  output var  logic                             wb_ack_o
);

  ////////////////////////////////////////////////////////////////////
  // state

  // whole block state; entry 0 does not exist, pointer 0 is empty
  typedef struct packed {
    logic [ras_pkg::RAS_DEPTH:1][20:0] entry;  // stack storage
    logic [4:0]                    ptr;        // pointer_bits
    logic                          full;       // stack_full_flag
    logic                          unf;        // stack_underflow_flag
    logic                          err_en;     // error reset enable
    ras_pkg::ras_regs_t            shadow;     // fast shadow copy
    ras_pkg::ras_rsp_t             rsp;        // sequencer answer
    logic                          ack;        // wishbone ack
    logic [31:0]                   rdat;       // wishbone read data
  } ras_state_t;

  ras_state_t state_q;  // registered state
  ras_state_t state_d;  // next state

  ////////////////////////////////////////////////////////////////////
  // decoding helpers

  // commands that push the pc
  function automatic logic ras_is_push(ras_pkg::ras_op_t op);
    ras_is_push = (op == ras_pkg::RAS_OP_CALL)
                | (op == ras_pkg::RAS_OP_INTACK)
                | (op == ras_pkg::RAS_OP_PUSH);
  endfunction : ras_is_push

  // commands that pop into the pc
  function automatic logic ras_is_ret(ras_pkg::ras_op_t op);
    ras_is_ret = (op == ras_pkg::RAS_OP_RETURN)
               | (op == ras_pkg::RAS_OP_RETLIT)
               | (op == ras_pkg::RAS_OP_RETINT);
  endfunction : ras_is_ret

  // value of the selected entry, zero when the stack is empty
  function automatic logic [20:0] ras_top(ras_state_t s);
    if (s.ptr == ras_pkg::RAS_PTR_EMPTY) begin
      ras_top = ras_pkg::RAS_PC_ZERO;
    end else begin
      ras_top = s.entry[s.ptr];  // [RL8]
    end
  endfunction : ras_top

  ////////////////////////////////////////////////////////////////////
  // next-state logic

  // bus first, then sequencer, then other resets, so later wins
  always_comb begin
    logic        bus_req;
    logic        bus_wr;
    logic [20:0] top;
    logic [20:0] push_pc;
    logic [4:0]  ptr_inc;
    bus_req = 1'b0;
    bus_wr  = 1'b0;
    top     = ras_top(state_q);
    push_pc = {req.pc[20:1], 1'b0};  // [RL24]
    ptr_inc = state_q.ptr + 5'h01;
    state_d = state_q;
    // one-cycle answers fall back to idle
    state_d.rsp.pc_load     = 1'b0;
    state_d.rsp.restore     = 1'b0;
    state_d.rsp.error_reset = 1'b0;
    state_d.ack             = 1'b0;

    // wishbone slave: answers one cycle after the strobe
    bus_req = wb_cyc_i & wb_stb_i & ~state_q.ack;
    bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    if (bus_req) begin
      state_d.ack  = 1'b1;
      state_d.rdat = 32'h00000000;  // unmapped reads as zero
      case (wb_adr_i)
        ras_pkg::RAS_OFS_PTR: begin
          // bit 5 reads as zero
          state_d.rdat[ras_pkg::RAS_BIT_FULL] = state_q.full;  // [RL16]
          state_d.rdat[ras_pkg::RAS_BIT_UNF]  = state_q.unf;   // [RL16]
          state_d.rdat[4:0] = state_q.ptr;                     // [RL9]
        end
        ras_pkg::RAS_OFS_TOL: state_d.rdat[7:0] = top[7:0];    // [RL8]
        ras_pkg::RAS_OFS_TOH: state_d.rdat[7:0] = top[15:8];   // [RL8]
        ras_pkg::RAS_OFS_TOU: state_d.rdat[4:0] = top[20:16];  // [RL8]
        ras_pkg::RAS_OFS_CFG: begin
          state_d.rdat[ras_pkg::RAS_BIT_CFG_EN] = state_q.err_en;
        end
        default: state_d.rdat = 32'h00000000;
      endcase
    end

    // register writes; flags clear on a written zero
    if (bus_wr) begin
      case (wb_adr_i)
        ras_pkg::RAS_OFS_PTR: begin
          state_d.ptr = wb_dat_i[4:0];  // [RL9]
          if (!wb_dat_i[ras_pkg::RAS_BIT_FULL]) begin
            state_d.full = 1'b0;  // [RL15]
          end
          if (!wb_dat_i[ras_pkg::RAS_BIT_UNF]) begin
            state_d.unf = 1'b0;  // [RL15]
          end
        end
        ras_pkg::RAS_OFS_TOL: begin
          // writes at pointer zero have no entry to land in
          if (state_q.ptr != ras_pkg::RAS_PTR_EMPTY) begin
            state_d.entry[state_q.ptr][7:0] = wb_dat_i[7:0];  // [RL8]
          end
        end
        ras_pkg::RAS_OFS_TOH: begin
          if (state_q.ptr != ras_pkg::RAS_PTR_EMPTY) begin
            state_d.entry[state_q.ptr][15:8] = wb_dat_i[7:0];  // [RL8]
          end
        end
        ras_pkg::RAS_OFS_TOU: begin
          if (state_q.ptr != ras_pkg::RAS_PTR_EMPTY) begin
            state_d.entry[state_q.ptr][20:16] = wb_dat_i[4:0];  // [RL8]
          end
        end
        ras_pkg::RAS_OFS_CFG: begin
          state_d.err_en = wb_dat_i[ras_pkg::RAS_BIT_CFG_EN];
        end
        default: ;  // unmapped writes are dropped
      endcase
    end

    // pushes; sequencer beats a same-cycle bus write to the pointer,
    // software is expected to mask interrupts around top access
    if (ras_is_push(req.op)) begin  // [RL2] [RL17]
      if (state_q.ptr == ras_pkg::RAS_PTR_MAX) begin
        // already full: nothing overwritten; pointer parked, or zeroed with error reset on
        state_d.full = 1'b1;  // [RL12]
        state_d.ptr  = ras_pkg::RAS_PTR_MAX;  // [RL12]
        if (state_q.err_en) begin
          state_d.rsp.error_reset = 1'b1;  // [RL14]
          state_d.ptr = ras_pkg::RAS_PTR_EMPTY;
        end
      end else if (state_q.ptr == ras_pkg::RAS_PTR_LAST) begin
        // the 31st push fills the stack
        state_d.full = 1'b1;  // [RL10]
        if (state_q.err_en) begin
          state_d.entry[ras_pkg::RAS_PTR_MAX] =
            push_pc + ras_pkg::RAS_PC_STEP;  // [RL11]
          state_d.rsp.error_reset = 1'b1;  // [RL11] [RL14]
          state_d.ptr = ras_pkg::RAS_PTR_EMPTY;  // [RL11]
        end else begin
          state_d.entry[ras_pkg::RAS_PTR_MAX] = push_pc;  // [RL12]
          state_d.ptr = ras_pkg::RAS_PTR_MAX;  // [RL12]
        end
      end else begin
        // increment first, then write the new slot
        state_d.ptr = ptr_inc;  // [RL5]
        state_d.entry[ptr_inc] = push_pc;  // [RL5] [RL1]
      end
    end

    // return-type pops; no pc latch is ever driven here
    if (ras_is_ret(req.op)) begin  // [RL3] [RL4]
      state_d.rsp.pc_load = 1'b1;
      if (state_q.ptr == ras_pkg::RAS_PTR_EMPTY) begin
        // underflow vectors to address zero, pointer stays
        state_d.rsp.pc_value = ras_pkg::RAS_PC_ZERO;  // [RL13]
        state_d.unf = 1'b1;  // [RL13]
        state_d.rsp.error_reset = state_q.err_en;  // [RL14]
      end else begin
        // read the entry, then decrement
        state_d.rsp.pc_value = {top[20:1], 1'b0};  // [RL6] [RL24]
        state_d.ptr = state_q.ptr - 5'h01;  // [RL6]
      end
    end

    // software pop discards the top entry only
    if (req.op == ras_pkg::RAS_OP_POP) begin
      if (state_q.ptr == ras_pkg::RAS_PTR_EMPTY) begin
        state_d.unf = 1'b1;  // [RL13]
        state_d.rsp.error_reset = state_q.err_en;  // [RL14]
      end else begin
        state_d.ptr = state_q.ptr - 5'h01;  // [RL18]
      end
    end

    // shadow save: every interrupt, or a fast call; one level only
    if ((req.op == ras_pkg::RAS_OP_INTACK) ||
        ((req.op == ras_pkg::RAS_OP_CALL) && req.fast)) begin
      state_d.shadow = req.regs;  // [RL19] [RL21] [RL23]
    end

    // shadow restore on fast return or fast return-from-interrupt
    if (req.fast && ((req.op == ras_pkg::RAS_OP_RETINT) ||
                     (req.op == ras_pkg::RAS_OP_RETURN))) begin
      state_d.rsp.restore = 1'b1;  // [RL20]
      state_d.rsp.regs    = state_q.shadow;  // [RL20]
    end

    // non-power-on resets empty the stack but keep the flags
    if (!dev_reset_n) begin
      state_d.ptr = ras_pkg::RAS_PTR_EMPTY;  // [RL7] [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // power-on reset clears everything, including both flags, but sets the error reset enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q        <= '0;
      state_q.ptr    <= ras_pkg::RAS_PTR_EMPTY;  // [RL7]
      state_q.err_en <= ras_pkg::RAS_CFG_EN_RST;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign rsp                  = state_q.rsp;
  assign stack_full_flag      = state_q.full;
  assign stack_underflow_flag = state_q.unf;
  assign wb_dat_o             = state_q.rdat;
  assign wb_ack_o             = state_q.ack;

endmodule : ras_return_address_stack

`default_nettype wire

// *** hdl/ras_pkg.sv ***
// ras_pkg: constants and types for the return-address stack.
// assumes: one clock, wishbone classic slave, core sequencer driver.
package ras_pkg;

  // stack geometry
  localparam int unsigned RAS_DEPTH = 31;
  localparam int unsigned RAS_PC_W  = 21;
  localparam int unsigned RAS_PTR_W = 5;
  localparam logic [4:0]  RAS_PTR_EMPTY = 5'h00;
  localparam logic [4:0]  RAS_PTR_MAX   = 5'h1F;
  localparam logic [4:0]  RAS_PTR_LAST  = 5'h1E;
  localparam logic [20:0] RAS_PC_STEP   = 21'h000002;
  localparam logic [20:0] RAS_PC_ZERO   = 21'h000000;

  // wishbone register map, byte addresses
  localparam int unsigned RAS_ADR_W   = 8;
  localparam logic [7:0]  RAS_OFS_PTR = 8'h00;
  localparam logic [7:0]  RAS_OFS_TOL = 8'h04;
  localparam logic [7:0]  RAS_OFS_TOH = 8'h08;
  localparam logic [7:0]  RAS_OFS_TOU = 8'h0C;
  localparam logic [7:0]  RAS_OFS_CFG = 8'h10;

  // pointer and config register fields
  localparam int unsigned RAS_BIT_FULL = 7;
  localparam int unsigned RAS_BIT_UNF  = 6;
  localparam int unsigned RAS_BIT_CFG_EN = 0;
  localparam logic        RAS_CFG_EN_RST = 1'b1;

  // sequencer commands
  typedef enum logic [2:0] {
    RAS_OP_NONE   = 3'b000,
    RAS_OP_CALL   = 3'b001,
    RAS_OP_INTACK = 3'b010,
    RAS_OP_RETURN = 3'b011,
    RAS_OP_RETLIT = 3'b100,
    RAS_OP_RETINT = 3'b101,
    RAS_OP_PUSH   = 3'b110,
    RAS_OP_POP    = 3'b111
  } ras_op_t;

  // status, working and bank-select values
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } ras_regs_t;

  // one-cycle command from the sequencer
  typedef struct packed {
    ras_op_t         op;
    logic            fast;
    logic [20:0]     pc;
    ras_regs_t       regs;
  } ras_req_t;

  // answers to the sequencer
  typedef struct packed {
    logic            pc_load;
    logic [20:0]     pc_value;
    logic            restore;
    ras_regs_t       regs;
    logic            error_reset;
  } ras_rsp_t;

endpackage : ras_pkg

// *** testbench/ras_chk.sv ***
// ras_chk: port-level checks on the return-address stack.
// assumes: bound into ras_return_address_stack, one clk domain.
`timescale 1ns/1ps
`default_nettype none

module ras_chk (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              dev_reset_n,
  input wire ras_pkg::ras_req_t req,
  input wire ras_pkg::ras_rsp_t rsp,
  input wire logic              stack_full_flag,
  input wire logic              stack_underflow_flag,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o
);
  //////////////////////////////////////////////////////////////////////
  // decoded events; a bus write counts only while ack is still low
  logic ret;
  logic fret;
  logic nold;
  logic pwr;
  assign ret  = req.op inside {ras_pkg::RAS_OP_RETURN,
                ras_pkg::RAS_OP_RETLIT, ras_pkg::RAS_OP_RETINT};
  assign fret = req.fast & (req.op inside {ras_pkg::RAS_OP_RETURN,
                ras_pkg::RAS_OP_RETINT});
  assign nold = req.op inside {ras_pkg::RAS_OP_CALL,
                ras_pkg::RAS_OP_INTACK, ras_pkg::RAS_OP_PUSH,
                ras_pkg::RAS_OP_POP};
  assign pwr  = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0]
                & (wb_adr_i == ras_pkg::RAS_OFS_PTR);

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  //////////////////////////////////////////////////////////////////////
  a_ret_load: assert property (ret |=> rsp.pc_load)
    else $error("return gave no pc load");
  a_push_noload: assert property (nold |=> !rsp.pc_load)
    else $error("push or discard loaded pc");
  a_pc_even: assert property (rsp.pc_load |-> !rsp.pc_value[0])
    else $error("odd pc returned");
  a_full_hold: assert property (stack_full_flag &&
    !(pwr && !wb_dat_i[7]) |=> stack_full_flag)
    else $error("full flag dropped without clear");
  a_unf_hold: assert property (stack_underflow_flag &&
    !(pwr && !wb_dat_i[6]) |=> stack_underflow_flag)
    else $error("underflow flag dropped without clear");
  a_fast_restore: assert property (fret |=> rsp.restore)
    else $error("fast return did not restore");
  a_shadow_regs: assert property (req.op == ras_pkg::RAS_OP_INTACK
    ##1 fret |=> rsp.regs == $past(req.regs, 2))
    else $error("shadow copy not from interrupt");
  a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("register access ack wrong");
endmodule : ras_chk

bind ras_return_address_stack ras_chk ras_chk_inst (
  .clk(clk), .rstn(rstn), .dev_reset_n(dev_reset_n), .req(req),
  .rsp(rsp), .stack_full_flag(stack_full_flag),
  .stack_underflow_flag(stack_underflow_flag), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o));

`default_nettype wire

// *** testbench/ras_seq_model.sv ***
// ras_seq_model: core sequencer side, one command per clock.
// assumes: its tasks are entered just after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none

module ras_seq_model (
  input  wire logic              clk,
  output var  ras_pkg::ras_req_t req
);
  // idle until asked; a stale op would repeat every cycle
  initial begin
    req = '0;
  end

  // command is held one cycle and taken at the next edge
  task automatic cmd(input ras_pkg::ras_op_t o, input logic f,
                     input logic [20:0] p, input logic [23:0] g);
    req <= '{o, f, p, g};
    @(posedge clk);
  endtask : cmd

  // release so back-to-back runs end cleanly
  task automatic idle();
    req.op <= ras_pkg::RAS_OP_NONE;
    @(posedge clk);
  endtask : idle
endmodule : ras_seq_model

`default_nettype wire

// *** testbench/ras_return_address_stack_test.sv ***
// ras_return_address_stack_test: directed wishbone and sequencer tests.
// assumes: ras_pkg compiled first, checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module ras_return_address_stack_test;
  logic              clk, rstn, dev_reset_n, wb_ack_o;
  logic              wb_cyc_i, wb_stb_i, wb_we_i;
  logic              stack_full_flag, stack_underflow_flag;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, rd;
  ras_pkg::ras_req_t req;
  ras_pkg::ras_rsp_t rsp;
  int                failures, compares;
  // push kinds and the return kinds they are popped with, paired by index
  ras_pkg::ras_op_t  pu [3] = '{ras_pkg::RAS_OP_CALL,
                     ras_pkg::RAS_OP_INTACK, ras_pkg::RAS_OP_PUSH};
  ras_pkg::ras_op_t  po [3] = '{ras_pkg::RAS_OP_RETURN,
                     ras_pkg::RAS_OP_RETLIT, ras_pkg::RAS_OP_RETINT};

  ras_seq_model ras_seq_model_inst (.clk(clk), .req(req));
  ras_return_address_stack ras_return_address_stack_inst (
    .clk(clk), .rstn(rstn), .dev_reset_n(dev_reset_n), .req(req),
    .rsp(rsp), .stack_full_flag(stack_full_flag),
    .stack_underflow_flag(stack_underflow_flag), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // one classic cycle, held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : acc

  // register read against an expected word
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rc

  // single command; the error request is sampled one edge later
  task automatic go(input ras_pkg::ras_op_t o, input logic [20:0] p,
                    input logic e);
    ras_seq_model_inst.cmd(o, 1'b0, p, 24'h0);
    ras_seq_model_inst.idle();
    `CHK(rsp.error_reset, e)
  endtask : go

  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #50000;
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    dev_reset_n = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rc(8'h00, 32'h00);
    rc(8'h10, 32'h01);
    acc(1'b1, 8'h14, 32'hFF);
    rc(8'h14, 32'h00);
    $display("test reset done");
    // each push kind against the return kind at the same index
    for (int i = 0; i < 3; i++) begin
      go(pu[i], 21'h012345 + 21'(i * 4), 1'b0);
      rc(8'h00, 32'h01);
      rc(8'h04, 32'h44 + 32'(i * 4));
      rc(8'h08, 32'h23);
      rc(8'h0C, 32'h01);
      go(po[i], 21'h0, 1'b0);
      `CHK(rsp.pc_value, 21'h012344 + 21'(i * 4))
    end
    rc(8'h00, 32'h00);
    $display("test push pop done");
    // pop on empty, then a non-power reset keeps the flag
    go(ras_pkg::RAS_OP_RETINT, 21'h0, 1'b1);
    `CHK(rsp.pc_value, 21'h0)
    dev_reset_n <= 1'b0;
    @(posedge clk);
    dev_reset_n <= 1'b1;
    rc(8'h00, 32'h40);
    acc(1'b1, 8'h00, 32'h0);
    rc(8'h00, 32'h00);
    $display("test underflow done");
    // error reset off: fill, overfill, discard, software push
    acc(1'b1, 8'h10, 32'h0);
    for (int i = 1; i <= 31; i++)
      go(ras_pkg::RAS_OP_CALL, 21'(2 * i), 1'b0);
    rc(8'h00, 32'h9F);
    go(ras_pkg::RAS_OP_CALL, 21'h100, 1'b0);
    rc(8'h00, 32'h9F);
    rc(8'h04, 32'h3E);
    go(ras_pkg::RAS_OP_POP, 21'h0, 1'b0);
    rc(8'h04, 32'h3C);
    go(ras_pkg::RAS_OP_PUSH, 21'h50, 1'b0);
    rc(8'h04, 32'h50);
    $display("test full hold done");
    // error reset on: 31st push stores pc plus two
    acc(1'b1, 8'h10, 32'h1);
    acc(1'b1, 8'h00, 32'h1E);
    go(ras_pkg::RAS_OP_CALL, 21'h40, 1'b1);
    rc(8'h00, 32'h80);
    acc(1'b1, 8'h00, 32'h9F);
    rc(8'h04, 32'h42);
    $display("test full reset done");
    // fast save and restore, interrupt overwrites the one level
    acc(1'b1, 8'h00, 32'h0);
    ras_seq_model_inst.cmd(ras_pkg::RAS_OP_CALL, 1'b1, 21'h300, 24'h111111);
    ras_seq_model_inst.cmd(ras_pkg::RAS_OP_RETURN, 1'b1, 21'h0, 24'h0);
    ras_seq_model_inst.idle();
    `CHK(rsp.regs, 24'h111111)
    ras_seq_model_inst.cmd(ras_pkg::RAS_OP_CALL, 1'b1, 21'h300, 24'h333333);
    ras_seq_model_inst.cmd(ras_pkg::RAS_OP_INTACK, 1'b0, 21'h400, 24'hA1B2C3);
    ras_seq_model_inst.cmd(ras_pkg::RAS_OP_RETINT, 1'b1, 21'h0, 24'h0);
    ras_seq_model_inst.idle();
    `CHK(rsp.regs, 24'hA1B2C3)
    $display("test shadow done");
    // top entry written by software, no interrupt in between
    acc(1'b1, 8'h00, 32'h02);
    acc(1'b1, 8'h04, 32'h56);
    acc(1'b1, 8'h08, 32'h34);
    acc(1'b1, 8'h0C, 32'h01);
    go(ras_pkg::RAS_OP_RETURN, 21'h0, 1'b0);
    `CHK(rsp.pc_value, 21'h013456)
    rc(8'h00, 32'h01);
    $display("test top write done");
    final_report();
  end
endmodule : ras_return_address_stack_test

`default_nettype wire
